// ===== rtl/gpio_pad_buffer_control.sv
// GPIO pad buffer control: configuration registers, power-up sequencing, pads
//
// Behaviour
// R01: Nineteen general pins, each independently an input or an output.
// R02: Double-drive bit selects 2x drive, otherwise 1x drive.
// R03: Drain-only bit makes the output drive low only; else push-pull.
// R04: Primary pull-up bit enables the pull-up regardless of the secondary bit.
// R05: Drive, type and pull-up settings are frozen once configuration is loaded.
// R06: Output enable and data follow the core continuously after configuration; the code holds them at their last values while the sleep pin is low.
// R07: While power-on reset is active every pin is high impedance.
// R08: Pins take configured settings only after reset release and a load.
// R09: Power-on reset releases only when both supplies are valid.
// R10: Each pin's pull-up is selectable independently of all others.
// R11: Sleep and power/reset pins are input only, never driven.
// R12: Pin data and enables pass through the core I/O buffer ring.
// R13: Power/reset pin falling puts outputs into hold or high-Z within 376 ns.
// R14: Secondary pull-up set alone is reserved and enables no pull-up.
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_buffer_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_supply_ok,
    input wire logic io_supply_ok,
    input wire logic power_reset_pin,
    input wire logic sleep_control_pin,
    input wire logic [18:0] pad_in,
    output logic [18:0] pad_out,
    output logic [18:0] pad_oe,
    output logic [18:0] pad_strong,
    output logic [18:0] pad_pullup
);
    // ==============================================================
    // Pin synchronisers
    logic [3:0] ctl_raw;
    logic [3:0] ctl_sync;
    logic [18:0] pad_in_sync;
    logic supplies_ok;
    logic reset_pin_high;
    logic awake;

    // Sleep and power/reset only ever enter through this path
    assign ctl_raw = {sleep_control_pin, power_reset_pin, io_supply_ok, core_supply_ok}; // [R11]

    sync_two_ff #(.WIDTH(4)) ctl_sync_u (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(ctl_raw),
        .sync_out(ctl_sync)
    );

    sync_two_ff #(.WIDTH(19)) pin_sync_u (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(pad_in),
        .sync_out(pad_in_sync) // [R12]
    );

    assign supplies_ok = ctl_sync[0] & ctl_sync[1]; // [R09]
    assign reset_pin_high = ctl_sync[2];
    assign awake = ctl_sync[3];

    // ==============================================================
    // APB decode
    logic access;
    logic wr_en;
    logic sel_drive;
    logic sel_drain;
    logic sel_pull_pri;
    logic sel_pull_sec;
    logic sel_ctrl;
    logic sel_out_en;
    logic sel_out_data;
    logic sel_in_data;
    logic sel_status;
    logic addr_hit;
    logic cfg_open;
    logic pready_ff;
    logic loaded_ff;
    logic wr_drive;
    logic wr_drain;
    logic wr_pull_pri;
    logic wr_pull_sec;
    logic wr_out_en;
    logic wr_out_data;

    assign access = psel & penable;
    assign wr_en = access & pwrite & pready_ff;
    assign sel_drive = (paddr == gpio_pad_pkg::OFS_DRIVE);
    assign sel_drain = (paddr == gpio_pad_pkg::OFS_DRAIN);
    assign sel_pull_pri = (paddr == gpio_pad_pkg::OFS_PULL_PRI);
    assign sel_pull_sec = (paddr == gpio_pad_pkg::OFS_PULL_SEC);
    assign sel_ctrl = (paddr == gpio_pad_pkg::OFS_CTRL);
    assign sel_out_en = (paddr == gpio_pad_pkg::OFS_OUT_EN);
    assign sel_out_data = (paddr == gpio_pad_pkg::OFS_OUT_DATA);
    assign sel_in_data = (paddr == gpio_pad_pkg::OFS_IN_DATA);
    assign sel_status = (paddr == gpio_pad_pkg::OFS_STATUS);
    assign addr_hit = sel_drive | sel_drain | sel_pull_pri | sel_pull_sec | sel_ctrl
        | sel_out_en | sel_out_data | sel_in_data | sel_status;
    // Static settings take writes only until the load is done
    assign cfg_open = ~loaded_ff; // [R05]
    // Per-register write strobes; static settings also need the gate open
    assign wr_drive = wr_en & sel_drive & cfg_open; // [R05]
    assign wr_drain = wr_en & sel_drain & cfg_open; // [R05]
    assign wr_pull_pri = wr_en & sel_pull_pri & cfg_open; // [R05]
    assign wr_pull_sec = wr_en & sel_pull_sec & cfg_open; // [R05]
    assign wr_out_en = wr_en & sel_out_en;
    assign wr_out_data = wr_en & sel_out_data;

    // ==============================================================
    // Device sequencing
    gpio_pad_pkg::dev_state_e state_ff;
    gpio_pad_pkg::dev_state_e nxt_state;
    logic nxt_loaded;
    logic [4:0] off_cnt_inc;
    logic load_ok;
    logic cfg_lost;
    logic [4:0] off_cnt_ff;
    logic [4:0] nxt_off_cnt;
    logic load_req;
    logic device_off;

    assign load_req = wr_en & sel_ctrl & pwdata[gpio_pad_pkg::CTRL_LOAD_BIT];
    // Holding the reset pin low long enough drops the loaded configuration
    assign device_off = (off_cnt_ff == gpio_pad_pkg::RET_DLY_CNT);
    assign off_cnt_inc = 5'(off_cnt_ff + 5'h0_1);
    assign nxt_off_cnt = reset_pin_high ? 5'h0_0 : (device_off ? off_cnt_ff : off_cnt_inc);
    // A supply drop or a long reset-pin low forgets the configuration
    assign cfg_lost = !supplies_ok || device_off;
    assign load_ok = load_req && (state_ff == gpio_pad_pkg::ST_UNCONFIGURED); // [R08]
    assign nxt_loaded = cfg_lost ? 1'b0 : (load_ok ? 1'b1 : loaded_ff); // [R09]

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            gpio_pad_pkg::ST_POR_HOLD:
            begin
                if (supplies_ok && reset_pin_high)
                begin
                    nxt_state = gpio_pad_pkg::ST_UNCONFIGURED; // [R09]
                end
            end
            gpio_pad_pkg::ST_UNCONFIGURED:
            begin
                if (!supplies_ok || !reset_pin_high)
                begin
                    nxt_state = gpio_pad_pkg::ST_POR_HOLD;
                end
                else if (load_req)
                begin
                    nxt_state = gpio_pad_pkg::ST_ACTIVE; // [R08]
                end
            end
            gpio_pad_pkg::ST_ACTIVE:
            begin
                if (!supplies_ok || !reset_pin_high)
                begin
                    nxt_state = gpio_pad_pkg::ST_POR_HOLD; // [R13]
                end
                else if (!awake)
                begin
                    nxt_state = gpio_pad_pkg::ST_RETAIN;
                end
            end
            gpio_pad_pkg::ST_RETAIN:
            begin
                if (!supplies_ok || !reset_pin_high)
                begin
                    nxt_state = gpio_pad_pkg::ST_POR_HOLD;
                end
                else if (awake)
                begin
                    nxt_state = gpio_pad_pkg::ST_ACTIVE;
                end
            end
            default:
            begin
                nxt_state = gpio_pad_pkg::ST_POR_HOLD;
            end
        endcase
        // A configuration still loaded after a short reset-pin low returns to active without a new load
        if (nxt_state == gpio_pad_pkg::ST_POR_HOLD && device_off)
        begin
            nxt_state = gpio_pad_pkg::ST_POR_HOLD;
        end
        else if (nxt_state == gpio_pad_pkg::ST_UNCONFIGURED && loaded_ff)
        begin
            nxt_state = gpio_pad_pkg::ST_ACTIVE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= gpio_pad_pkg::ST_POR_HOLD;
            loaded_ff <= 1'b0;
            off_cnt_ff <= 5'h0_0;
        end
        else
        begin
            state_ff <= nxt_state;
            loaded_ff <= nxt_loaded;
            off_cnt_ff <= nxt_off_cnt;
        end
    end

    // ==============================================================
    // Configuration and dynamic registers
    logic [18:0] drive_ff;
    logic [18:0] drain_ff;
    logic [18:0] pull_pri_ff;
    logic [18:0] pull_sec_ff;
    logic [18:0] out_en_ff;
    logic [18:0] out_data_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_ff <= gpio_pad_pkg::CFG_RST;
            drain_ff <= gpio_pad_pkg::CFG_RST;
            pull_pri_ff <= gpio_pad_pkg::CFG_RST;
            pull_sec_ff <= gpio_pad_pkg::CFG_RST;
            out_en_ff <= gpio_pad_pkg::CFG_RST;
            out_data_ff <= gpio_pad_pkg::CFG_RST;
        end
        else
        begin
            if (wr_drive)
            begin
                drive_ff <= pwdata[18:0]; // [R02] [R05]
            end
            if (wr_drain)
            begin
                drain_ff <= pwdata[18:0]; // [R03] [R05]
            end
            if (wr_pull_pri)
            begin
                pull_pri_ff <= pwdata[18:0]; // [R10] [R05]
            end
            if (wr_pull_sec)
            begin
                pull_sec_ff <= pwdata[18:0]; // [R05]
            end
            // Dynamic controls accept writes at any time
            if (wr_out_en)
            begin
                out_en_ff <= pwdata[18:0]; // [R06] [R01]
            end
            if (wr_out_data)
            begin
                out_data_ff <= pwdata[18:0]; // [R06]
            end
        end
    end

    // ==============================================================
    // Read path: one wait state so read data comes from a flip-flop
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic force_hiz;

    assign status_word = {27'h000_0000,
        force_hiz, ~awake, reset_pin_high, loaded_ff, ~supplies_ok};

    assign rd_mux = sel_drive ? {13'h0000, drive_ff} :
        sel_drain ? {13'h0000, drain_ff} :
        sel_pull_pri ? {13'h0000, pull_pri_ff} :
        sel_pull_sec ? {13'h0000, pull_sec_ff} :
        sel_ctrl ? {31'h0000_0000, loaded_ff} :
        sel_out_en ? {13'h0000, out_en_ff} :
        sel_out_data ? {13'h0000, out_data_ff} :
        sel_in_data ? {13'h0000, pad_in_sync} : // [R12]
        sel_status ? status_word :
        gpio_pad_pkg::RDATA_RST;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= gpio_pad_pkg::RDATA_RST;
        end
        else
        begin
            pready_ff <= access & ~pready_ff;
            pslverr_ff <= access & ~pready_ff & ~addr_hit;
            prdata_ff <= (access && !pready_ff && !pwrite) ? rd_mux : gpio_pad_pkg::RDATA_RST;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ==============================================================
    // Pad stages
    logic hold;

    // Any state but active or retention keeps every driver off
    assign force_hiz = (state_ff == gpio_pad_pkg::ST_POR_HOLD)
        || (state_ff == gpio_pad_pkg::ST_UNCONFIGURED) || !supplies_ok
        || !reset_pin_high; // [R07] [R08] [R13]
    assign hold = (state_ff == gpio_pad_pkg::ST_RETAIN);

    genvar gi;
    generate
        for (gi = 0; gi < gpio_pad_pkg::NUM_PINS; gi++)
        begin : g_pad
            pad_output_stage pad_u (
                .mclk(mclk),
                .rst_n(rst_n),
                .force_hiz(force_hiz),
                .hold(hold),
                .double_drive_select(drive_ff[gi]),
                .drain_only_select(drain_ff[gi]),
                .primary_pullup_select(pull_pri_ff[gi]), // [R10]
                .core_oe(out_en_ff[gi]),
                .core_data(out_data_ff[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe(pad_oe[gi]), // [R01]
                .pad_strong(pad_strong[gi]),
                .pad_pullup(pad_pullup[gi])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ===== rtl/gpio_pad_pkg.sv
// Constants, register map and states of the GPIO pad buffer control block
package gpio_pad_pkg;
    // ==============================================================
    // Geometry
    localparam int NUM_PINS = 19;
    localparam int ADDR_W = 8;
    // ==============================================================
    // Register byte offsets
    localparam logic [7:0] OFS_DRIVE = 8'h00;
    localparam logic [7:0] OFS_DRAIN = 8'h04;
    localparam logic [7:0] OFS_PULL_PRI = 8'h08;
    localparam logic [7:0] OFS_PULL_SEC = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_OUT_EN = 8'h14;
    localparam logic [7:0] OFS_OUT_DATA = 8'h18;
    localparam logic [7:0] OFS_IN_DATA = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // ==============================================================
    // Field positions
    localparam int CTRL_LOAD_BIT = 0;
    localparam int STAT_POR_BIT = 0;
    localparam int STAT_LOADED_BIT = 1;
    localparam int STAT_RESET_PIN_BIT = 2;
    localparam int STAT_SLEEP_BIT = 3;
    localparam int STAT_HIZ_BIT = 4;
    // ==============================================================
    // Reset values
    localparam logic [18:0] CFG_RST = 19'h0_0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // ==============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RET_DLY_NS = 376;
    // Longest time: round down
    localparam int RET_DLY_CYC = RET_DLY_NS / CLK_PERIOD_NS;
    localparam logic [4:0] RET_DLY_CNT = 5'(RET_DLY_CYC);
    // ==============================================================
    // Device states
    typedef enum logic [1:0] {
        ST_POR_HOLD,
        ST_UNCONFIGURED,
        ST_ACTIVE,
        ST_RETAIN
    } dev_state_e;
endpackage

// ===== rtl/sync_two_ff.sv
// Two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ==============================================================
    // Stage one is read only by stage two
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ===== rtl/pad_output_stage.sv
// Registered output stage of one GPIO pad
`timescale 1ns/1ns
`default_nettype none
module pad_output_stage (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic force_hiz,
    input wire logic hold,
    input wire logic double_drive_select,
    input wire logic drain_only_select,
    input wire logic primary_pullup_select,
    input wire logic core_oe,
    input wire logic core_data,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_strong,
    output logic pad_pullup
);
    // ==============================================================
    // Output stage decode
    logic nxt_out;
    logic nxt_oe;
    logic out_ff;
    logic oe_ff;
    logic strong_ff;
    logic pullup_ff;

    // Open drain drives only a low, push-pull drives the data
    assign nxt_out = drain_only_select ? 1'b0 : core_data; // [R03]
    assign nxt_oe = drain_only_select ? (core_oe & ~core_data) : core_oe; // [R03] [R06]

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            strong_ff <= 1'b0;
            pullup_ff <= 1'b0;
        end
        else if (force_hiz)
        begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0; // [R07]
            strong_ff <= 1'b0;
            pullup_ff <= 1'b0;
        end
        else if (!hold)
        begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            strong_ff <= double_drive_select; // [R02]
            // Secondary pull-up alone is reserved and enables nothing
            pullup_ff <= primary_pullup_select; // [R04] [R14]
        end
    end

    assign pad_out = out_ff;
    assign pad_oe = oe_ff;
    assign pad_strong = strong_ff;
    assign pad_pullup = pullup_ff;
endmodule
`default_nettype wire

// ===== testbench/gpio_pad_buffer_control_props.sv
// Port-level assertion checker for the GPIO pad buffer control block
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_buffer_control_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_supply_ok,
    input wire logic io_supply_ok,
    input wire logic power_reset_pin,
    input wire logic sleep_control_pin,
    input wire logic [18:0] pad_in,
    input wire logic [18:0] pad_out,
    input wire logic [18:0] pad_oe,
    input wire logic [18:0] pad_strong,
    input wire logic [18:0] pad_pullup
);
    // ==========
    // Sequences
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // Margin covers the two-stage synchroniser plus the pad register
    sequence s_supply_low;
        (!core_supply_ok || !io_supply_ok) [*6];
    endsequence
    sequence s_retain;
        (!sleep_control_pin && core_supply_ok && io_supply_ok && power_reset_pin) [*5];
    endsequence
    // ==========
    // Assertions
    a_apb_one_wait: assert property (s_access |=> pready)
        else $error("pready late");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_pready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == '0)
        else $error("bad error response");
    a_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not idle");
    a_supply_hiz: assert property (s_supply_low |-> pad_oe == '0 && pad_pullup == '0)
        else $error("pads driven without supplies");
    a_pin_fall_hiz: assert property ($fell(power_reset_pin) |-> ##[1:18] pad_oe == '0)
        else $error("pads not released after reset pin");
    a_sleep_hold: assert property (s_retain |=> $stable(pad_oe) && $stable(pad_out))
        else $error("pads moved while asleep");
endmodule
bind gpio_pad_buffer_control gpio_pad_buffer_control_props u_props (.mclk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_supply_ok,
    .io_supply_ok, .power_reset_pin, .sleep_control_pin, .pad_in, .pad_out, .pad_oe,
    .pad_strong, .pad_pullup);
`default_nettype wire

// ===== testbench/pin_board.sv
// Board-side model of the pins: wire resolution and external drivers
`timescale 1ns/1ns
`default_nettype none
module pin_board (
    input wire logic mclk,
    input wire logic [18:0] pad_out,
    input wire logic [18:0] pad_oe,
    input wire logic [18:0] pad_pullup,
    input wire logic [18:0] ext_en,
    input wire logic [18:0] ext_val,
    output logic [18:0] pad_in
);
    // Floating pins toggle so a stale level never passes as valid
    logic [18:0] float_ff;
    initial float_ff = 19'h0_0000;
    always @(posedge mclk) float_ff <= ~float_ff;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pad_pullup | float_ff));
endmodule
`default_nettype wire

// ===== testbench/gpio_pad_buffer_control_tb.sv
// Self-checking bench for the GPIO pad buffer control block
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_buffer_control_tb;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic core_supply_ok, io_supply_ok, power_reset_pin, sleep_control_pin;
    logic [18:0] pad_in, pad_out, pad_oe, pad_strong, pad_pullup, ext_en, ext_val;
    logic [18:0] drv, drn, pri, sec, oe, dat, hold;
    int err_count = 0;
    int checks = 0;
    int seed = 32'h1352_bad0;
    gpio_pad_buffer_control u_gpio_pad_buffer_control (.mclk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_supply_ok,
        .io_supply_ok, .power_reset_pin, .sleep_control_pin, .pad_in, .pad_out, .pad_oe,
        .pad_strong, .pad_pullup);
    pin_board u_pin_board (.mclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val,
        .pad_in);
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ==========
    // Helpers
    task automatic final_report;
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic wr_cfg;
        apb(1'b1, gpio_pad_pkg::OFS_DRIVE, {13'h0, drv});
        apb(1'b1, gpio_pad_pkg::OFS_DRAIN, {13'h0, drn});
        apb(1'b1, gpio_pad_pkg::OFS_PULL_PRI, {13'h0, pri});
        apb(1'b1, gpio_pad_pkg::OFS_PULL_SEC, {13'h0, sec});
    endtask
    task automatic wr_out;
        apb(1'b1, gpio_pad_pkg::OFS_OUT_EN, {13'h0, oe});
        apb(1'b1, gpio_pad_pkg::OFS_OUT_DATA, {13'h0, dat});
        repeat (3) @(posedge mclk);
    endtask
    task automatic load;
        apb(1'b1, gpio_pad_pkg::OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge mclk);
    endtask
    function automatic logic [18:0] exp_oe(input logic ld);
        return ld ? (oe & ~(drn & dat)) : 19'h0_0000;
    endfunction
    function automatic logic [18:0] exp_in(input logic [18:0] m);
        return (m & dat & ~drn) | (~m & ext_en & ext_val) | (~m & ~ext_en & pri);
    endfunction
    task automatic check_pads(input logic ld);
        logic [18:0] m;
        m = exp_oe(ld);
        chk({13'h0, pad_oe}, {13'h0, m});
        chk({13'h0, pad_out & m}, {13'h0, dat & ~drn & m});
        chk({13'h0, pad_strong}, {13'h0, ld ? drv : 19'h0_0000});
        chk({13'h0, pad_pullup}, {13'h0, ld ? pri : 19'h0_0000});
    endtask
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        final_report;
    end
    // ==========
    // Sequence
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        core_supply_ok = 1'b0;
        io_supply_ok = 1'b0;
        power_reset_pin = 1'b1;
        sleep_control_pin = 1'b1;
        ext_en = 19'h0_0000;
        ext_val = 19'h0_0000;
        {drv, drn, pri, sec} = {4{19'($random(seed))}} ^ {19'h5_5555, 19'h3_0f0f, 38'h0};
        sec = 19'($random(seed));
        oe = 19'h7_ffff;
        dat = 19'($random(seed));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        core_supply_ok <= 1'b1;
        wr_cfg;
        wr_out;
        load;
        check_pads(1'b0);
        rd_chk(gpio_pad_pkg::OFS_STATUS, 32'h0000_0015);
        io_supply_ok <= 1'b1;
        repeat (4) @(posedge mclk);
        check_pads(1'b0);
        load;
        check_pads(1'b1);
        rd_chk(gpio_pad_pkg::OFS_STATUS, 32'h0000_0006);
        rd_chk(gpio_pad_pkg::OFS_CTRL, 32'h0000_0001);
        rd_chk(gpio_pad_pkg::OFS_PULL_PRI, {13'h0, pri});
        rd_chk(gpio_pad_pkg::OFS_PULL_SEC, {13'h0, sec});
        rd_chk(8'h24, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        hold = drv;
        drv = ~drv;
        wr_cfg;
        drv = hold;
        check_pads(1'b1);
        rd_chk(gpio_pad_pkg::OFS_DRIVE, {13'h0, hold});
        for (int i = 0; i < 12; i++)
        begin
            oe = (i == 0) ? 19'h0_0000 : 19'($random(seed)) | {19{i == 1}};
            dat = 19'($random(seed));
            ext_en <= 19'($random(seed)) & ~oe;
            ext_val <= 19'($random(seed));
            wr_out;
            check_pads(1'b1);
            apb(1'b0, gpio_pad_pkg::OFS_IN_DATA, 32'h0000_0000);
            hold = exp_oe(1'b1) | ext_en | pri;
            chk({13'h0, rd[18:0] & hold}, {13'h0, exp_in(exp_oe(1'b1)) & hold});
        end
        sleep_control_pin <= 1'b0;
        repeat (5) @(posedge mclk);
        hold = exp_oe(1'b1);
        oe = ~oe;
        wr_out;
        chk({13'h0, pad_oe}, {13'h0, hold});
        rd_chk(gpio_pad_pkg::OFS_STATUS, 32'h0000_000e);
        rd_chk(gpio_pad_pkg::OFS_OUT_EN, {13'h0, oe});
        sleep_control_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        check_pads(1'b1);
        oe = 19'h7_ffff;
        dat = 19'h0_0000;
        wr_out;
        power_reset_pin <= 1'b0;
        repeat (18) @(posedge mclk);
        chk({13'h0, pad_oe}, 32'h0000_0000);
        repeat (25) @(posedge mclk);
        power_reset_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        check_pads(1'b0);
        load;
        check_pads(1'b1);
        io_supply_ok <= 1'b0;
        repeat (8) @(posedge mclk);
        check_pads(1'b0);
        final_report;
    end
endmodule
`default_nettype wire
